/* design/oma_arbiter.sv */
// Operation mode arbiter: picks the source of run and frequency commands.
// Assumes synchronous terminal inputs and a lone AHB-Lite master.
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
module oma_arbiter
  import oma_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        panel_interlock_input,
  input  wire logic        output_stop_input,
  input  wire logic        panel_external_switch_input,
  input  wire logic        network_panel_switch_input,
  input  wire logic        external_network_switch_input,
  input  wire logic        forward_start_input,
  input  wire logic        reverse_start_input,
  input  wire logic        motor_running,
  input  wire logic        x65_assigned,
  input  wire logic        x66_assigned,
  input  wire logic        x16_assigned,
  input  wire logic [15:0] ext_freq_cmd,
  input  wire logic [15:0] net_freq_cmd,
  input  wire logic        net_dir_reverse,
  input  wire logic        panel_run,
  input  wire logic        panel_dir_reverse,
  output logic      [1:0]  op_mode,
  output logic             output_stop,
  output logic             run_cmd,
  output logic             dir_reverse,
  output logic      [15:0] freq_cmd,
  output logic             param_write_enable
);

  // --------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [15:0] panel_freq;
  logic        rejected;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        rd_pend;
  logic [7:0]  rd_addr;
  logic [3:0]  cmd_pulse;
  oma_mode_t   mode;
  logic        interlock_on;
  logic        start_any;
  logic        stopped;
  logic        wr_allowed;

  wire logic [3:0] mode_sel  = ctrl[OMA_CTRL_MODE_LSB +: 4];
  wire logic [1:0] stop_logic = ctrl[OMA_CTRL_STOP_LSB +: 2];
  wire logic [3:0] comm_start = ctrl[OMA_CTRL_COMM_LSB +: 4];
  wire logic [1:0] wsel       = ctrl[OMA_CTRL_WSEL_LSB +: 2];
  wire logic       x12_assigned = ctrl[OMA_CTRL_X12_BIT];
  wire logic       addr_phase = hsel & hready & htrans[1];

  // Address phase capture; every access completes with zero wait states.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
    end else begin
      wr_pend <= addr_phase & hwrite;
      rd_pend <= addr_phase & ~hwrite;
      if (addr_phase) begin
        wr_addr <= haddr[7:0];
        rd_addr <= haddr[7:0];
      end
    end
  end

  // Slave is always ready and always answers OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Write gate: write select 1, or interlock off in setting 7, rejects control and frequency writes, all but the mode setting.
  always_comb begin
    wr_allowed = (wsel != 2'h1);
    if (mode_sel == OMA_SET_ILK && !interlock_on) begin
      wr_allowed = 1'b0;
    end
  end

  // Control register; the mode setting field is always writable.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= OMA_CTRL_RST;
    end else if (wr_pend && wr_addr == OMA_CTRL_OFS) begin
      ctrl[OMA_CTRL_MODE_LSB +: 4] <= hwdata[OMA_CTRL_MODE_LSB +: 4];
      if (wr_allowed) begin
        ctrl <= hwdata & 32'h0001_3F3F;
        ctrl[OMA_CTRL_WSEL_LSB +: 2] <= hwdata[OMA_CTRL_WSEL_LSB +: 2];
      end
    end
  end

  // Panel frequency setting, subject to the same write gate.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      panel_freq <= OMA_FREQ_RST[15:0];
    end else if (wr_pend && wr_addr == OMA_FREQ_OFS && wr_allowed) begin
      panel_freq <= hwdata[15:0];
    end
  end

  // Sticky flag of rejected writes; a new rejection wins over the clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rejected <= 1'b0;
    end else if (wr_pend && !wr_allowed &&
                 (wr_addr == OMA_FREQ_OFS || wr_addr == OMA_CTRL_OFS)) begin
      rejected <= 1'b1;
    end else if (wr_pend && wr_addr == OMA_STATUS_OFS && hwdata[OMA_ST_REJ_BIT]) begin
      rejected <= 1'b0;
    end
  end

  // Command register writes become one-cycle requests.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_pulse <= 4'h0;
    end else if (wr_pend && wr_addr == OMA_CMD_OFS) begin
      cmd_pulse <= hwdata[3:0];
    end else begin
      cmd_pulse <= 4'h0;
    end
  end

  // Read data in the data phase; unmapped addresses read zero.
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_pend) begin
      case (rd_addr)
        OMA_CTRL_OFS:   hrdata = ctrl;
        OMA_STATUS_OFS: hrdata = {23'h0, rejected, 3'h0, interlock_on,
                                  output_stop, run_cmd, op_mode};
        OMA_FREQ_OFS:   hrdata = {16'h0, panel_freq};
        default:        hrdata = 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Interlock source and status
  // --------------------------------------------------------------------
  always_comb begin
    if (x12_assigned) begin
      interlock_on = panel_interlock_input;
    end else begin
      interlock_on = output_stop_input ^ (stop_logic == OMA_STOP_INV);
    end
  end

  assign start_any = forward_start_input | reverse_start_input;
  assign stopped   = ~motor_running & ~start_any;

  // --------------------------------------------------------------------
  // Mode resolution
  // --------------------------------------------------------------------
  oma_mode_t next_mode;
  logic      may_switch;

  always_comb begin
    next_mode  = mode;
    may_switch = stopped || (mode_sel == OMA_SET_SWO);
    case (mode_sel)
      OMA_SET_PU:  next_mode = OMA_PANEL;
      OMA_SET_CB3, OMA_SET_CB4: next_mode = OMA_COMB;
      OMA_SET_EXT, OMA_SET_0, OMA_SET_SWO, OMA_SET_ILK: begin
        if (mode_sel == OMA_SET_ILK && !interlock_on) begin
          next_mode = OMA_EXT;
        end else if (x66_assigned && may_switch) begin
          next_mode = external_network_switch_input ? OMA_NET : OMA_EXT;
        end else if (x65_assigned && may_switch && mode_sel != OMA_SET_EXT) begin
          next_mode = network_panel_switch_input ? OMA_PANEL : OMA_NET;
        end else if (cmd_pulse[OMA_CMD_NET_BIT] && may_switch) begin
          next_mode = OMA_NET;
        end else if (cmd_pulse[OMA_CMD_NETEXT_BIT] && may_switch) begin
          next_mode = OMA_EXT;
        end else if (cmd_pulse[OMA_CMD_PANEL_BIT] && may_switch &&
                     mode_sel != OMA_SET_EXT &&
                     !(mode_sel == OMA_SET_ILK && start_any)) begin
          next_mode = OMA_PANEL;
        end else if (cmd_pulse[OMA_CMD_EXTKEY_BIT] && may_switch) begin
          next_mode = OMA_EXT;
        end else if (x16_assigned && may_switch && mode_sel != OMA_SET_EXT &&
                     mode != OMA_NET) begin
          next_mode = panel_external_switch_input ? OMA_EXT : OMA_PANEL;
        end else if (mode == OMA_PANEL && mode_sel == OMA_SET_EXT) begin
          next_mode = OMA_EXT;
        end else if (mode == OMA_COMB) begin
          next_mode = OMA_EXT;
        end
      end
      default: next_mode = OMA_EXT;
    endcase
  end

  // Mode register; reset enters external, as the startup check only sees the control word at its reset value and never selects network.
  logic boot;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= OMA_EXT;
      boot <= 1'b1;
    end else begin
      boot <= 1'b0;
      if (boot && comm_start == OMA_COMM_NET &&
          (mode_sel == OMA_SET_0 || mode_sel == OMA_SET_EXT)) begin
        mode <= OMA_NET;
      end else begin
        mode <= next_mode;
      end
    end
  end

  // --------------------------------------------------------------------
  // Command source and held values
  // --------------------------------------------------------------------
  logic [15:0] held_freq;
  logic        held_dir;
  logic        held_valid;

  // Values kept across a switch; cleared by reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_freq  <= 16'h0000;
      held_dir   <= 1'b0;
      held_valid <= 1'b0;
    end else if (mode != next_mode && !boot) begin
      held_freq  <= freq_cmd;
      held_dir   <= dir_reverse;
      held_valid <= (next_mode == OMA_PANEL || next_mode == OMA_NET);
    end else if (panel_run && mode == OMA_PANEL) begin
      held_valid <= 1'b0;
    end
  end

  // Output drive per mode.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_mode            <= 2'h0;
      output_stop        <= 1'b0;
      run_cmd            <= 1'b0;
      dir_reverse        <= 1'b0;
      freq_cmd           <= 16'h0000;
      param_write_enable <= 1'b0;
    end else begin
      op_mode            <= mode;
      param_write_enable <= wr_allowed;
      if (mode_sel == OMA_SET_ILK && !x12_assigned) begin
        output_stop <= interlock_on && mode == OMA_EXT;
      end else if (mode_sel == OMA_SET_ILK) begin
        output_stop <= output_stop_input | (interlock_on && mode == OMA_EXT);
      end else begin
        output_stop <= output_stop_input;
      end
      case (mode)
        OMA_EXT: begin
          run_cmd     <= start_any;
          dir_reverse <= reverse_start_input & ~forward_start_input;
          freq_cmd    <= ext_freq_cmd;
        end
        OMA_PANEL: begin
          run_cmd     <= panel_run | (held_valid & motor_running);
          dir_reverse <= held_valid ? held_dir : panel_dir_reverse;
          freq_cmd    <= held_valid ? held_freq : panel_freq;
        end
        OMA_NET: begin
          run_cmd     <= motor_running | held_valid;
          dir_reverse <= held_valid ? held_dir : net_dir_reverse;
          freq_cmd    <= held_valid ? held_freq : net_freq_cmd;
        end
        default: begin
          run_cmd     <= start_any;
          dir_reverse <= reverse_start_input & ~forward_start_input;
          freq_cmd    <= panel_freq;
        end
      endcase
    end
  end

endmodule : oma_arbiter

/* inc/oma_pkg.sv */
// Package for the operation mode arbiter: register map, settings, modes.
// Assumes a single AHB-Lite slave on a 32-bit bus with word-aligned registers.
package oma_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OMA_CTRL_OFS   = 8'h00;  // Settings and write select.
  localparam logic [7:0] OMA_CMD_OFS    = 8'h04;  // Key and network commands.
  localparam logic [7:0] OMA_STATUS_OFS = 8'h08;  // Mode and source status.
  localparam logic [7:0] OMA_FREQ_OFS   = 8'h0C;  // Panel frequency setting.

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int OMA_CTRL_MODE_LSB  = 0;   // mode_select_param, 4 bits.
  localparam int OMA_CTRL_STOP_LSB  = 4;   // stop_input_logic_param, 2 bits.
  localparam int OMA_CTRL_COMM_LSB  = 8;   // comm_startup_mode_param, 4 bits.
  localparam int OMA_CTRL_WSEL_LSB  = 12;  // param_write_select, 2 bits.
  localparam int OMA_CTRL_X12_BIT   = 16;  // Interlock function assigned.
  localparam int OMA_CMD_PANEL_BIT  = 0;   // Panel key: go to panel mode.
  localparam int OMA_CMD_EXTKEY_BIT = 1;   // Panel key: go to external mode.
  localparam int OMA_CMD_NET_BIT    = 2;   // Network: go to network mode.
  localparam int OMA_CMD_NETEXT_BIT = 3;   // Network: go to external mode.
  localparam int OMA_ST_REJ_BIT     = 8;   // Sticky: a write was rejected.

  // ----------------------------------------------------------------------
  // Reset values and setting codes
  // ----------------------------------------------------------------------
  localparam logic [31:0] OMA_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] OMA_FREQ_RST = 32'h0000_0000;
  localparam logic [3:0]  OMA_SET_0    = 4'h0;
  localparam logic [3:0]  OMA_SET_PU   = 4'h1;
  localparam logic [3:0]  OMA_SET_EXT  = 4'h2;
  localparam logic [3:0]  OMA_SET_CB3  = 4'h3;
  localparam logic [3:0]  OMA_SET_CB4  = 4'h4;
  localparam logic [3:0]  OMA_SET_SWO  = 4'h6;
  localparam logic [3:0]  OMA_SET_ILK  = 4'h7;
  localparam logic [1:0]  OMA_STOP_INV = 2'h2;
  localparam logic [3:0]  OMA_COMM_NET = 4'h1;  // Start from network mode.

  // ----------------------------------------------------------------------
  // Operation modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    OMA_EXT,
    OMA_PANEL,
    OMA_NET,
    OMA_COMB
  } oma_mode_t;

endpackage : oma_pkg

/* tb/oma_arbiter_asserts.sv */
// Checker for the operation mode arbiter, watching only the top ports.
// Assumes one AHB-Lite master and terminal levels synchronous to hclk.
`timescale 1ns/1ns
module oma_arbiter_asserts
  import oma_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        panel_interlock_input,
  input wire logic        output_stop_input,
  input wire logic        panel_external_switch_input,
  input wire logic        forward_start_input,
  input wire logic        reverse_start_input,
  input wire logic        motor_running,
  input wire logic        x16_assigned,
  input wire logic        x65_assigned,
  input wire logic        x66_assigned,
  input wire logic [15:0] ext_freq_cmd,
  input wire logic [1:0]  op_mode,
  input wire logic        output_stop,
  input wire logic        dir_reverse,
  input wire logic [15:0] freq_cmd,
  input wire logic        param_write_enable
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic       ph_ctl;
  logic [3:0] mode_sh;
  logic [1:0] stop_sh;
  logic [1:0] wsel_sh;
  logic       ilk_sh;
  logic       on_ilk;
  logic       locked;

  // Shadow of the control word, so the checker knows the setting in force.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_ctl  <= 1'b0;
      mode_sh <= 4'h0;
      stop_sh <= 2'h0;
      wsel_sh <= 2'h0;
      ilk_sh  <= 1'b0;
    end else if (hready) begin
      ph_ctl <= hsel && htrans[1] && hwrite && (haddr == 32'(OMA_CTRL_OFS));
      if (ph_ctl) begin
        mode_sh <= hwdata[3:0];
        if (!locked) begin
          stop_sh <= hwdata[5:4];
          wsel_sh <= hwdata[13:12];
          ilk_sh  <= hwdata[16];
        end
      end
    end
  end

  // The borrowed stop input may be inverted; a dedicated terminal is not.
  assign on_ilk = ilk_sh ? panel_interlock_input : (output_stop_input ^ (stop_sh == OMA_STOP_INV));
  assign locked = (wsel_sh == 2'h1) || ((mode_sh == OMA_SET_ILK) && !on_ilk);

  sequence s_x16_rise;
    $rose(panel_external_switch_input) && x16_assigned && !x65_assigned && !x66_assigned;
  endsequence
  sequence s_stopped;
    !motor_running && !forward_start_input && !reverse_start_input && (mode_sh == OMA_SET_0);
  endsequence

  a_ready_always: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  a_fixed_panel: assert property ((mode_sh == OMA_SET_PU) [*4] |-> op_mode == OMA_PANEL)
    else $error("setting 1 not in panel mode");
  a_fixed_comb: assert property ((mode_sh == OMA_SET_CB3 || mode_sh == OMA_SET_CB4) [*4]
    |-> op_mode == OMA_COMB) else $error("setting 3 or 4 not combined");
  a_ilk_forces_ext: assert property ((mode_sh == OMA_SET_ILK && !on_ilk) [*4]
    |-> op_mode == OMA_EXT) else $error("interlock off but not external");
  a_write_locked: assert property ((mode_sh == OMA_SET_ILK && !on_ilk) [*4]
    |-> !param_write_enable) else $error("writes open with interlock off");
  a_ext_out_stop: assert property ((mode_sh == OMA_SET_ILK && on_ilk && op_mode == OMA_EXT) [*3]
    |-> output_stop) else $error("external output not stopped");
  a_x16_to_ext: assert property (s_x16_rise and s_stopped |-> ##[1:4] op_mode == OMA_EXT)
    else $error("switch input did not select external");
  a_ext_freq: assert property ((op_mode == OMA_EXT && $stable(ext_freq_cmd)) [*3]
    |-> freq_cmd == ext_freq_cmd) else $error("external frequency not used");
  a_ext_dir: assert property ((op_mode == OMA_EXT && reverse_start_input && !forward_start_input)
    [*3] |-> dir_reverse) else $error("external direction not used");
endmodule : oma_arbiter_asserts

bind oma_arbiter oma_arbiter_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .panel_interlock_input, .output_stop_input,
  .panel_external_switch_input, .forward_start_input, .reverse_start_input, .motor_running,
  .x16_assigned, .x65_assigned, .x66_assigned, .ext_freq_cmd, .op_mode, .output_stop,
  .dir_reverse, .freq_cmd, .param_write_enable);

/* tb/oma_field_model.sv */
// Field side: the motor and the terminal function configuration.
// Assumes the drive's run and output stop outputs are synchronous to hclk.
`timescale 1ns/1ns
module oma_field_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic run_cmd,
  input  wire logic output_stop,
  input  wire logic x16_cfg,
  input  wire logic x66_cfg,
  output logic      motor_running,
  output logic      x16_assigned,
  output logic      x65_assigned,
  output logic      x66_assigned
);
  logic [1:0] spin;

  // The motor spins up and coasts down over two cycles.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spin <= 2'h0;
    end else begin
      spin <= {spin[0], run_cmd & ~output_stop};
    end
  end

  // Terminal functions as the configuring party assigned them.
  assign motor_running = spin[1];
  assign x16_assigned  = x16_cfg;
  assign x65_assigned  = 1'b0;
  assign x66_assigned  = x66_cfg;
endmodule : oma_field_model

/* tb/testbench.sv */
// Self-checking bench for the operation mode arbiter.
// Assumes the design answers each AHB-Lite transfer with hreadyout.
`timescale 1ns/1ns
module testbench
  import oma_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0]  htrans = 2'h0, op_mode;
  logic [2:0]  hsize = 3'h2;
  logic        panel_interlock_input = 1'b0, output_stop_input = 1'b0, x16_cfg = 1'b0;
  logic        panel_external_switch_input = 1'b0, network_panel_switch_input = 1'b0;
  logic        external_network_switch_input = 1'b0, forward_start_input = 1'b0;
  logic        reverse_start_input = 1'b0, net_dir_reverse = 1'b0, panel_run = 1'b0;
  logic        panel_dir_reverse = 1'b0, motor_running, x65_assigned, x66_assigned;
  logic        x16_assigned, hreadyout, hresp, output_stop, run_cmd, dir_reverse;
  logic        param_write_enable, x66_cfg = 1'b0;
  logic [15:0] ext_freq_cmd = 16'h0000, net_freq_cmd = 16'h0555, freq_cmd;
  int          err_count = 0, checked = 0, cyc = 0;

  oma_arbiter dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .panel_interlock_input, .output_stop_input,
    .panel_external_switch_input, .network_panel_switch_input, .external_network_switch_input,
    .forward_start_input, .reverse_start_input, .motor_running, .x65_assigned, .x66_assigned,
    .x16_assigned, .ext_freq_cmd, .net_freq_cmd, .net_dir_reverse, .panel_run,
    .panel_dir_reverse, .op_mode, .output_stop, .run_cmd, .dir_reverse, .freq_cmd,
    .param_write_enable);
  oma_field_model u_field (.hclk, .hresetn, .run_cmd, .output_stop, .x16_cfg, .motor_running,
    .x16_assigned, .x65_assigned, .x66_assigned, .x66_cfg);

  // Clock and a cycle ceiling that cuts a hang short.
  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic cm(input oma_mode_t m);
    chk(32'(op_mode), 32'(m));
  endtask : cm
  // One single word transfer; read data is taken at the data phase edge.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 32'(a);
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic settle();
    repeat (5) @(posedge hclk);
    @(negedge hclk);
  endtask : settle
  task automatic wrs(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
    settle();
  endtask : wrs

  task automatic t_regs();
    ahb(1'b0, OMA_CTRL_OFS, 32'h0);
    chk(r, OMA_CTRL_RST);
    ahb(1'b0, OMA_FREQ_OFS, 32'h0);
    chk(r, OMA_FREQ_RST);
    ahb(1'b0, 8'h10, 32'h0);
    chk(32'(hresp), 32'h0000_0000);
    cm(OMA_EXT);
    $display("test regs done");
  endtask : t_regs

  task automatic t_swo();
    wrs(OMA_CTRL_OFS, 32'h0000_0006);
    @(posedge hclk);
    ext_freq_cmd <= 16'h1234;
    forward_start_input <= 1'b1;
    wrs(OMA_CMD_OFS, 32'h0000_0001);
    cm(OMA_PANEL);
    chk(32'(run_cmd), 32'h1);
    chk(32'(freq_cmd), 32'h1234);
    wrs(OMA_CMD_OFS, 32'h0000_0004);
    cm(OMA_NET);
    chk(32'(freq_cmd), 32'h1234);
    wrs(OMA_CMD_OFS, 32'h0000_0001);
    cm(OMA_PANEL);
    chk(32'(freq_cmd), 32'h1234);
    @(posedge hclk);
    ext_freq_cmd <= 16'h0abc;
    forward_start_input <= 1'b0;
    reverse_start_input <= 1'b1;
    wrs(OMA_CMD_OFS, 32'h0000_0002);
    cm(OMA_EXT);
    chk({16'h0, freq_cmd} | 32'(dir_reverse) << 16, 32'h0001_0abc);
    wrs(OMA_CMD_OFS, 32'h0000_0004);
    cm(OMA_NET);
    chk({16'h0, freq_cmd} | 32'(dir_reverse) << 16, 32'h0001_0abc);
    @(posedge hclk);
    ext_freq_cmd <= 16'h0777;
    wrs(OMA_CMD_OFS, 32'h0000_0008);
    cm(OMA_EXT);
    chk(32'(freq_cmd), 32'h0777);
    @(posedge hclk);
    reverse_start_input <= 1'b0;
    $display("test switch-over done");
  endtask : t_swo

  task automatic t_ilk();
    @(posedge hclk);
    output_stop_input <= 1'b1;
    wrs(OMA_CTRL_OFS, 32'h0000_0007);
    chk(32'(output_stop), 32'h1);
    wrs(OMA_CMD_OFS, 32'h0000_0001);
    cm(OMA_PANEL);
    @(posedge hclk);
    output_stop_input <= 1'b0;
    settle();
    cm(OMA_EXT);
    chk(32'(param_write_enable), 32'h0);
    ahb(1'b1, OMA_FREQ_OFS, 32'h0000_0055);
    ahb(1'b0, OMA_STATUS_OFS, 32'h0);
    chk(r & 32'h0000_0100, 32'h0000_0100);
    @(posedge hclk);
    output_stop_input <= 1'b1;
    wrs(OMA_STATUS_OFS, 32'h0000_0100);
    wrs(OMA_CTRL_OFS, 32'h0000_0027);
    cm(OMA_EXT);
    chk(32'(param_write_enable), 32'h0);
    @(posedge hclk);
    output_stop_input <= 1'b0;
    settle();
    wrs(OMA_CMD_OFS, 32'h0000_0001);
    cm(OMA_PANEL);
    wrs(OMA_CTRL_OFS, 32'h0000_0000);
    @(posedge hclk);
    output_stop_input <= 1'b1;
    settle();
    chk(32'(output_stop), 32'h1);
    $display("test interlock done");
  endtask : t_ilk

  task automatic t_x16();
    @(posedge hclk);
    output_stop_input <= 1'b0;
    x16_cfg <= 1'b1;
    settle();
    cm(OMA_PANEL);
    @(posedge hclk);
    panel_external_switch_input <= 1'b1;
    settle();
    cm(OMA_EXT);
    @(posedge hclk);
    forward_start_input <= 1'b1;
    settle();
    @(posedge hclk);
    panel_external_switch_input <= 1'b0;
    settle();
    cm(OMA_EXT);
    @(posedge hclk);
    forward_start_input <= 1'b0;
    wrs(OMA_CTRL_OFS, 32'h0000_0001);
    @(posedge hclk);
    panel_external_switch_input <= 1'b1;
    settle();
    cm(OMA_PANEL);
    wrs(OMA_CTRL_OFS, 32'h0000_0003);
    cm(OMA_COMB);
    wrs(OMA_CTRL_OFS, 32'h0000_0004);
    cm(OMA_COMB);
    $display("test switch input done");
  endtask : t_x16

  task automatic t_start_lock();
    @(posedge hclk);
    x16_cfg <= 1'b0;
    output_stop_input <= 1'b1;
    forward_start_input <= 1'b1;
    wrs(OMA_CTRL_OFS, 32'h0000_0007);
    wrs(OMA_CMD_OFS, 32'h0000_0001);
    cm(OMA_EXT);
    chk(32'(output_stop), 32'h1);
    $display("test start lock done");
  endtask : t_start_lock

  // Dedicated interlock terminal, then the network switch below the interlock in priority.
  task automatic t_x12();
    @(posedge hclk);
    forward_start_input <= 1'b0;
    panel_interlock_input <= 1'b1;
    wrs(OMA_CTRL_OFS, 32'h0001_0007);
    chk(32'(output_stop), 32'h1);
    wrs(OMA_CMD_OFS, 32'h0000_0001);
    cm(OMA_PANEL);
    @(posedge hclk);
    panel_interlock_input <= 1'b0;
    x66_cfg <= 1'b1;
    external_network_switch_input <= 1'b1;
    settle();
    cm(OMA_EXT);
    chk(32'(param_write_enable), 32'h0);
    @(posedge hclk);
    panel_interlock_input <= 1'b1;
    settle();
    cm(OMA_NET);
    $display("test interlock terminal done");
  endtask : t_x12

  task automatic end_of_test();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Reset for 20 cycles, then the scenarios in turn.
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_swo();
    t_ilk();
    t_x16();
    t_start_lock();
    t_x12();
    end_of_test();
  end
endmodule : testbench
